// ==== dv/esp_host_model.sv ====
// Host model: serial bus master sending one unit per chip select frame.
// Assumes the bench resolves the shared data line and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module esp_host_model (
    // Link pins driven by the host
    output var logic ser_clk_out,
    output var logic chip_select_n_out,
    output var logic data_command_sel_out,
    output var logic sda_val_out,
    output var logic sda_drv_out,
    // Resolved data line and framing strap
    input wire logic sda_line_in,
    input wire logic bus_width_strap_in
);
    localparam realtime HALF = 62.5;
    // Idle: clock parked low, deselected, host owns the data line
    initial
    begin
        ser_clk_out = 1'b0;
        chip_select_n_out = 1'b1;
        data_command_sel_out = 1'b0;
        sda_val_out = 1'b0;
        sda_drv_out = 1'b1;
    end
    // Data changes after the fall, is sampled at the rise
    task automatic bit_cycle(input logic drv, input logic v, output logic s);
        sda_drv_out = drv;
        sda_val_out = v;
        #HALF ser_clk_out = 1'b1;
        s = sda_line_in;
        #HALF ser_clk_out = 1'b0;
    endtask
    // Clock edges with select high, which the device must ignore
    task automatic stray();
        logic s;
        repeat (3) bit_cycle(1'b1, 1'b1, s);
    endtask
    // nb below 8 abandons the unit; released bits toggle so stale data fails
    task automatic unit(input logic dc, input logic [7:0] wb, input logic rd,
        input int nb, output logic [7:0] rb);
        logic s;
        rb = 8'h00;
        chip_select_n_out = 1'b0;
        data_command_sel_out = dc;
        if (bus_width_strap_in)
            bit_cycle(1'b1, dc, s);
        for (int i = 7; i > 7 - nb; i--)
        begin
            bit_cycle(!rd, rd ? ~sda_val_out : wb[i], s);
            rb[i] = s;
        end
        #HALF chip_select_n_out = 1'b1;
        sda_drv_out = 1'b1;
        #600;
    endtask
endmodule
`default_nettype wire

// ==== dv/esp_port_properties.sv ====
// Checker for the serial host port, watching only the top-level ports.
// Assumes it is bound to every instance of the port by the bind below.
`timescale 1ns/1ps
`default_nettype none
module esp_port_checker (
    // Core clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Link pins
    input wire logic ser_clk_in,
    input wire logic chip_select_n_in,
    input wire logic bus_width_strap_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    // Decoded stream and readback address
    input wire logic cmd_valid_out,
    input wire logic param_valid_out,
    input wire logic [7:0] param_idx_out,
    input wire logic [15:0] otp_addr_out
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic first_q, first_d;
    logic [7:0] last_q, last_d;
    // Parameter numbering restarts at every command
    always_comb
    begin
        first_d = cmd_valid_out ? 1'b1 : (param_valid_out ? 1'b0 : first_q);
        last_d = param_valid_out ? param_idx_out : last_q;
    end
    // Registers for the numbering tracker
    always_ff @(posedge core_clk_in or negedge rst_n_in)
        if (!rst_n_in)
            {first_q, last_q} <= 9'h100;
        else
            {first_q, last_q} <= {first_d, last_d};

    property p_oe_cs; sda_oe_out |-> !chip_select_n_in; endproperty
    a_oe_cs:
        assert property (p_oe_cs) else $error("data driven while deselected");
    property p_kind; cmd_valid_out |-> !param_valid_out; endproperty
    a_kind:
        assert property (p_kind) else $error("unit typed both ways");
    // A unit takes at least five core clocks, so pulses never crowd
    property p_gap;
        (cmd_valid_out || param_valid_out)
            |=> !(cmd_valid_out || param_valid_out) [*4];
    endproperty
    a_gap:
        assert property (p_gap) else $error("stream pulses too close");
    property p_first; param_valid_out && first_q |-> param_idx_out == 8'h00;
    endproperty
    a_first:
        assert property (p_first) else $error("first parameter not index 0");
    property p_next;
        param_valid_out && !first_q |-> param_idx_out ==
            ((last_q == 8'hff) ? 8'hff : last_q + 8'h01);
    endproperty
    a_next:
        assert property (p_next) else $error("parameter index skipped");
    property p_otp;
        $changed(otp_addr_out) |-> otp_addr_out == 16'h0000 ||
            otp_addr_out == $past(otp_addr_out) + 16'h0001;
    endproperty
    a_otp:
        assert property (p_otp) else $error("readback address jumped");
    // Half a link period exceeds a core period: one link edge per sample
    property p_shift;
        $rose(ser_clk_in) && $past(sda_oe_out) && sda_oe_out
            |-> $stable(sda_out);
    endproperty
    a_shift:
        assert property (p_shift) else $error("read data moved on rise");
    property p_wait3;
        $fell(chip_select_n_in) && bus_width_strap_in |-> !sda_oe_out;
    endproperty
    a_wait3:
        assert property (p_wait3) else $error("3-wire drive before flag");
    property p_rst;
        $rose(rst_n_in) |-> !cmd_valid_out && !param_valid_out &&
            otp_addr_out == 16'h0000 && !sda_oe_out;
    endproperty
    a_rst:
        assert property (p_rst) else $error("outputs busy out of reset");
endmodule

bind esp_serial_host_port esp_port_checker esp_port_checker_i (
    .core_clk_in, .rst_n_in, .ser_clk_in, .chip_select_n_in,
    .bus_width_strap_in, .sda_out, .sda_oe_out, .cmd_valid_out,
    .param_valid_out, .param_idx_out, .otp_addr_out);
`default_nettype wire

// ==== dv/esp_serial_host_port_bench.sv ====
// Bench: host model on the link, queue scoreboard on the decoded stream.
// Assumes the package, design, checker and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module esp_serial_host_port_bench import esp_pkg::*;;
    logic core_clk, rst_n, strap, sclk, cs_n, dc, hval, hdrv, line;
    logic sda_o, oe, cmd_v, par_v;
    logic [7:0] rdata, odata, bout, idx;
    logic [15:0] oaddr;
    logic [16:0] exp_q[$];
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    // Released line shows the inverse of the host's last bit
    assign line = oe ? sda_o : (hdrv ? hval : ~hval);
    assign odata = oaddr[7:0] ^ 8'h5a;
    esp_serial_host_port esp_serial_host_port_i (.core_clk_in(core_clk),
        .rst_n_in(rst_n), .ser_clk_in(sclk), .chip_select_n_in(cs_n),
        .data_command_sel_in(dc), .sda_in(line), .sda_out(sda_o),
        .sda_oe_out(oe), .bus_width_strap_in(strap), .cmd_valid_out(cmd_v),
        .param_valid_out(par_v), .byte_out(bout), .param_idx_out(idx),
        .read_data_in(rdata), .otp_addr_out(oaddr), .otp_data_in(odata));
    esp_host_model esp_host_model_i (.ser_clk_out(sclk),
        .chip_select_n_out(cs_n), .data_command_sel_out(dc),
        .sda_val_out(hval), .sda_drv_out(hdrv), .sda_line_in(line),
        .bus_width_strap_in(strap));
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Each stream pulse takes the oldest expected unit off the queue
    always @(posedge core_clk)
        if (cmd_v === 1'b1 || par_v === 1'b1)
            check({cmd_v, bout, par_v ? idx : 8'h00},
                (exp_q.size() == 0) ? 17'h1ffff : exp_q.pop_front());
    // Hang guard, far above the roughly 1800 cycles the two runs need
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end
    // Command then n parameter bytes, of which only lim are expected
    task automatic burst(input logic [7:0] cmd, input int n, input int lim);
        logic [7:0] b, r;
        exp_q.push_back({1'b1, cmd, 8'h00});
        esp_host_model_i.unit(1'b0, cmd, 1'b0, 8, r);
        for (int i = 0; i < n; i++)
        begin
            b = 8'($urandom);
            if (i < lim)
                exp_q.push_back({1'b0, b, 8'(i)});
            esp_host_model_i.unit(1'b1, b, 1'b0, 8, r);
        end
    endtask
    task automatic rd(input logic [7:0] e);
        logic [7:0] r;
        esp_host_model_i.unit(1'b1, 8'h00, 1'b1, 8, r);
        check({9'h000, r}, {9'h000, e});
    endtask
    // Whole sequence in one framing mode, strap fixed under reset
    task automatic run(input logic mode);
        logic [7:0] r;
        @(negedge core_clk);
        strap = mode;
        rst_n = 1'b0;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        burst(8'h90, 9, 7);
        esp_host_model_i.unit(1'b0, 8'h5a, 1'b0, 3, r);
        burst(8'h82, 2, 1);
        esp_host_model_i.stray();
        burst(8'h91, 0, 0);
        burst(8'h10, 3, 3);
        @(negedge core_clk) rdata = 8'($urandom);
        burst(ESP_CMD_VCOM_VALUE, 0, 0);
        rd(rdata);
        burst(ESP_CMD_READ_OTP, 0, 0);
        rd(ESP_DUMMY_BYTE);
        for (int a = 0; a < 3; a++)
            rd(8'(a) ^ 8'h5a);
        check({16'h0000, exp_q.size() == 0}, 17'h00001);
    endtask
    initial
    begin
        rst_n = 1'b0;
        strap = 1'b0;
        rdata = 8'h00;
        void'($urandom(32'h222b05ba));
        run(1'b0);
        run(1'b1);
        stop_test();
    end
endmodule
`default_nettype wire

// ==== hdl/esp_pkg.sv ====
// Constants and types for the serial host port of the panel controller.
// Assumes a single core clock domain plus the host-driven serial clock.
package esp_pkg;

    // Unit widths in serial clock edges
    localparam logic [3:0] ESP_BITS_4W = 4'h8;
    localparam logic [3:0] ESP_BITS_3W = 4'h9;

    // Command codes the port itself must know about
    localparam logic [7:0] ESP_CMD_VCOM_VALUE = 8'h81;
    localparam logic [7:0] ESP_CMD_READ_OTP = 8'ha2;

    // Readback values
    localparam logic [7:0] ESP_DUMMY_BYTE = 8'h00;
    localparam logic [15:0] ESP_OTP_ADDR_MAX = 16'hffff;
    localparam logic [15:0] ESP_OTP_ADDR_RST = 16'h0000;

    // Parameter count marker for commands with an open-ended stream
    localparam logic [7:0] ESP_PARAM_STREAM = 8'hff;

    // Read source selected by the last command
    typedef enum logic [1:0]
    {
        ESP_RD_NONE = 2'b00,
        ESP_RD_REG = 2'b01,
        ESP_RD_OTP = 2'b10
    } esp_rd_t;

    // Defined parameter count per command; unknown codes stream freely
    function automatic logic [7:0] esp_param_count(input logic [7:0] cmd);
        logic [7:0] n;
        n = ESP_PARAM_STREAM;
        case (cmd)
            8'h81, 8'h91, 8'h92, 8'ha0, 8'ha1, 8'ha2: n = 8'h00;
            8'h82, 8'he0, 8'he3, 8'he4, 8'he5: n = 8'h01;
            8'h90: n = 8'h07;
            default: n = ESP_PARAM_STREAM;
        endcase
        return n;
    endfunction

endpackage

// ==== hdl/esp_serial_host_port.sv ====
// Serial host port: 3-wire / 4-wire serial slave with core-side decode.
// Assumes the host gaps chip select for a few core clocks between units
// so that read bytes staged by the core are stable before they are sent.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Serial traffic counts only while chip select is low; edges otherwise ignored.
// - Incoming bits are sampled on serial clock rising edges, MSB first.
// - Parameters beyond a command's defined count are dropped silently.
// - 4-wire mode uses 8-bit units, typed by the data/command pin.
// - Chip select rising clears the bit counter; partial units are abandoned.
// - 3-wire mode uses 9-bit units; first bit is the data/command flag.
// - 4-wire read with pin high drives read MSB once chip select falls.
// - 3-wire read with first bit high drives MSB after first falling edge.
// - OTP readback returns a dummy byte first; host discards it.
// - OTP readback then returns bytes from address zero upward, 16-bit bound.
module esp_serial_host_port
    import esp_pkg::*;
(
    // Core clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Serial link pins
    input wire logic ser_clk_in,
    input wire logic chip_select_n_in,
    input wire logic data_command_sel_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Strap: high selects 3-wire framing
    input wire logic bus_width_strap_in,
    // Decoded write stream toward the core
    output logic cmd_valid_out,
    output logic param_valid_out,
    output logic [7:0] byte_out,
    output logic [7:0] param_idx_out,
    // Read sources
    input wire logic [7:0] read_data_in,
    output logic [15:0] otp_addr_out,
    input wire logic [7:0] otp_data_in
);

    // Link domain: counters cleared by reset or by chip select high; hand-off by reset only
    logic link_rst_n;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d;
    logic flag_q, flag_d;
    logic [7:0] unit_byte_q, unit_byte_d;
    logic unit_dc_q, unit_dc_d;
    logic ev_tgl_q, ev_tgl_d;
    logic [3:0] fall_cnt_q, fall_cnt_d;
    logic sdo_q, sdo_d;
    logic [3:0] unit_len;
    logic [3:0] out_bit;

    // Core domain
    logic [2:0] ev_sync_q;
    logic ev_seen_q, ev_seen_d;
    logic [2:0] strap_sync_q;
    logic three_wire_q, three_wire_d;
    esp_rd_t rd_mode_q, rd_mode_d;
    logic [7:0] rd_byte_q, rd_byte_d;
    logic [15:0] otp_addr_q, otp_addr_d;
    logic [7:0] cur_cmd_q, cur_cmd_d;
    logic [7:0] pcnt_q, pcnt_d;
    logic cmd_v_q, cmd_v_d;
    logic par_v_q, par_v_d;
    logic [7:0] byte_q, byte_d;
    logic [7:0] pidx_q, pidx_d;
    logic ev_new;

    // Counter restarts whenever chip select is high
    assign link_rst_n = rst_n_in & ~chip_select_n_in;
    // The strap mode is quasi-static, so the link reads the core's synchronised three_wire_q copy directly
    assign unit_len = three_wire_q ? ESP_BITS_3W : ESP_BITS_4W;

    // Receive path on rising edges
    always_comb
    begin
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        flag_d = flag_q;
        unit_byte_d = unit_byte_q;
        unit_dc_d = unit_dc_q;
        ev_tgl_d = ev_tgl_q;
        if (three_wire_q && bit_cnt_q == 4'h0)
        begin
            flag_d = sda_in;
        end
        else
        begin
            shift_d = {shift_q[6:0], sda_in};
        end
        if (bit_cnt_q == unit_len - 4'h1)
        begin
            // Unit complete: hand off, extra edges wait for next unit
            bit_cnt_d = 4'h0;
            unit_byte_d = {shift_q[6:0], sda_in};
            unit_dc_d = three_wire_q ? flag_q : data_command_sel_in;
            ev_tgl_d = ~ev_tgl_q;
        end
        else
        begin
            bit_cnt_d = bit_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge ser_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            flag_q <= 1'b0;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            flag_q <= flag_d;
        end
    end

    // Hand-off word and toggle survive chip select; only reset clears
    always_ff @(posedge ser_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            unit_byte_q <= 8'h00;
            unit_dc_q <= 1'b0;
            ev_tgl_q <= 1'b0;
        end
        else
        begin
            unit_byte_q <= unit_byte_d;
            unit_dc_q <= unit_dc_d;
            ev_tgl_q <= ev_tgl_d;
        end
    end

    // Transmit path: next bit chosen on falling edges
    always_comb
    begin
        fall_cnt_d = fall_cnt_q;
        if (fall_cnt_q != 4'hf)
        begin
            fall_cnt_d = fall_cnt_q + 4'h1;
        end
        // 4-wire: bit 7 already out, falls step to 6..0; 3-wire lags one
        out_bit = three_wire_q ? 4'h7 - fall_cnt_q : 4'h6 - fall_cnt_q;
        sdo_d = (out_bit <= 4'h7) ? rd_byte_q[out_bit[2:0]] : 1'b0;
    end

    always_ff @(negedge ser_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            fall_cnt_q <= 4'h0;
            sdo_q <= 1'b0;
        end
        else
        begin
            fall_cnt_q <= fall_cnt_d;
            sdo_q <= sdo_d;
        end
    end

    // Pin drive: read units only, as typed by pin or leading flag
    always_comb
    begin
        sda_oe_out = 1'b0;
        sda_out = 1'b0;
        if (!chip_select_n_in && rd_mode_q != ESP_RD_NONE)
        begin
            if (!three_wire_q && data_command_sel_in)
            begin
                sda_oe_out = 1'b1;
                sda_out = (fall_cnt_q == 4'h0) ? rd_byte_q[7] : sdo_q;
            end
            else if (three_wire_q && flag_q && fall_cnt_q != 4'h0)
            begin
                sda_oe_out = 1'b1;
                sda_out = sdo_q;
            end
        end
    end

    // Event toggle and strap cross in three flops; act when 2nd and 3rd agree
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ev_sync_q <= 3'h0;
            strap_sync_q <= 3'h0;
        end
        else
        begin
            ev_sync_q <= {ev_sync_q[1:0], ev_tgl_q};
            strap_sync_q <= {strap_sync_q[1:0], bus_width_strap_in};
        end
    end

    assign ev_new = (ev_sync_q[1] == ev_sync_q[2]) && (ev_sync_q[2] != ev_seen_q);

    // Core decode: commands, bounded parameters, read staging
    always_comb
    begin
        ev_seen_d = ev_seen_q;
        three_wire_d = three_wire_q;
        rd_mode_d = rd_mode_q;
        rd_byte_d = rd_byte_q;
        otp_addr_d = otp_addr_q;
        cur_cmd_d = cur_cmd_q;
        pcnt_d = pcnt_q;
        cmd_v_d = 1'b0;
        par_v_d = 1'b0;
        byte_d = byte_q;
        pidx_d = pidx_q;
        if (strap_sync_q[1] == strap_sync_q[2])
        begin
            three_wire_d = strap_sync_q[2];
        end
        if (ev_new)
        begin
            ev_seen_d = ev_sync_q[2];
            byte_d = unit_byte_q;
            if (!unit_dc_q)
            begin
                cmd_v_d = 1'b1;
                cur_cmd_d = unit_byte_q;
                pcnt_d = 8'h00;
                pidx_d = 8'h00;
                if (unit_byte_q == ESP_CMD_READ_OTP)
                begin
                    rd_mode_d = ESP_RD_OTP;
                    rd_byte_d = ESP_DUMMY_BYTE;
                    otp_addr_d = ESP_OTP_ADDR_RST;
                end
                else if (unit_byte_q == ESP_CMD_VCOM_VALUE)
                begin
                    rd_mode_d = ESP_RD_REG;
                    rd_byte_d = read_data_in;
                end
                else
                begin
                    rd_mode_d = ESP_RD_NONE;
                end
            end
            else
            begin
                unique case (rd_mode_q)
                    ESP_RD_OTP:
                    begin
                        rd_byte_d = otp_data_in;
                        if (otp_addr_q != ESP_OTP_ADDR_MAX)
                        begin
                            otp_addr_d = otp_addr_q + 16'h0001;
                        end
                    end
                    ESP_RD_REG:
                    begin
                        rd_byte_d = read_data_in;
                    end
                    ESP_RD_NONE:
                    begin
                        // Surplus beyond the defined count is dropped
                        if (esp_param_count(cur_cmd_q) == ESP_PARAM_STREAM ||
                            pcnt_q < esp_param_count(cur_cmd_q))
                        begin
                            par_v_d = 1'b1;
                            pidx_d = pcnt_q;
                            if (pcnt_q != 8'hff)
                            begin
                                pcnt_d = pcnt_q + 8'h01;
                            end
                        end
                    end
                    default:
                    begin
                        rd_mode_d = ESP_RD_NONE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ev_seen_q <= 1'b0;
            three_wire_q <= 1'b0;
            rd_mode_q <= ESP_RD_NONE;
            rd_byte_q <= 8'h00;
            otp_addr_q <= ESP_OTP_ADDR_RST;
            cur_cmd_q <= 8'h00;
            pcnt_q <= 8'h00;
            cmd_v_q <= 1'b0;
            par_v_q <= 1'b0;
            byte_q <= 8'h00;
            pidx_q <= 8'h00;
        end
        else
        begin
            ev_seen_q <= ev_seen_d;
            three_wire_q <= three_wire_d;
            rd_mode_q <= rd_mode_d;
            rd_byte_q <= rd_byte_d;
            otp_addr_q <= otp_addr_d;
            cur_cmd_q <= cur_cmd_d;
            pcnt_q <= pcnt_d;
            cmd_v_q <= cmd_v_d;
            par_v_q <= par_v_d;
            byte_q <= byte_d;
            pidx_q <= pidx_d;
        end
    end

    // Core-side outputs straight from flops
    assign cmd_valid_out = cmd_v_q;
    assign param_valid_out = par_v_q;
    assign byte_out = byte_q;
    assign param_idx_out = pidx_q;
    assign otp_addr_out = otp_addr_q;

endmodule

`default_nettype wire
